// ### logic/rtcct_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef RTCCT_REGS_SVH
`define RTCCT_REGS_SVH
`define RTCCT_ADDR_DAY        4'h4
`define RTCCT_ADDR_MONTH      4'h5
`define RTCCT_ADDR_YEAR       4'h6
`define RTCCT_ADDR_TRIM       4'h7
`define RTCCT_ADDR_AMIN       4'h8
`define RTCCT_ADDR_AHOUR      4'h9
`define RTCCT_ADDR_BMIN       4'hb
`define RTCCT_ADDR_BHOUR      4'hc
`define RTCCT_DAY_MASK        8'h3f
`define RTCCT_MONTH_MASK      8'h1f
`define RTCCT_MIN_MASK        8'h7f
`define RTCCT_HOUR_MASK       8'h3f
`define RTCCT_TRIM_RESET      8'h00
`define RTCCT_TRIM_XSEL_BIT   7
`define RTCCT_TRIM_SIGN_BIT   6
`define RTCCT_HOUR_PM_BIT     5
`define RTCCT_CYC_32768       17'h08000
`define RTCCT_CYC_32000       17'h07d00
`define RTCCT_DAY_RESET       8'h01
`define RTCCT_MONTH_RESET     8'h01
`define RTCCT_YEAR_RESET      8'h00
`define RTCCT_ALARM_RESET     8'h00
`endif

// ### logic/rtcct_pkg.sv
// types shared by the calendar, trim and alarm logic
package rtcct_pkg;
    typedef struct packed {
        logic [7:0] minute;
        logic [7:0] hour;
    } rtcct_alarm_type;
    typedef struct packed {
        logic       write;
        logic [3:0] addr;
        logic [7:0] data;
    } rtcct_wr_type;
    typedef enum logic [1:0] {
        RTCCT_MONTH_LONG  = 2'b00,
        RTCCT_MONTH_SHORT = 2'b01,
        RTCCT_MONTH_FEB   = 2'b10
    } rtcct_month_kind_type;
endpackage

// ### logic/rtcct_bcd_digit.sv
// wrapping two-digit bcd counter with programmable first and last value
`timescale 1ns/1ns
module rtcct_bcd_digit #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] value,   // present bcd value
    input  wire logic [WIDTH-1:0] first,   // value after wrap
    input  wire logic [WIDTH-1:0] last,    // highest value
    output logic      [WIDTH-1:0] stepped, // value after one step
    output logic                  wrapped  // step wraps to first
);
    logic [7:0] wide;
    logic [7:0] inc;
    initial begin
        if (WIDTH < 1 || WIDTH > 8) begin
            $error("bcd digit width out of range");
        end
    end
    always_comb begin
        wide = 8'h00;
        wide[WIDTH-1:0] = value;
        inc = (wide[3:0] >= 4'h9) ? {wide[7:4] + 4'h1, 4'h0} : wide + 8'h01;
        wrapped = (value == last);
        stepped = wrapped ? first : inc[WIDTH-1:0];
    end
endmodule

// ### logic/rtcct_alarm_cmp.sv
// compares one alarm minute and hour against the live counters
`timescale 1ns/1ns
module rtcct_alarm_cmp (
    input  wire logic                     clk,       // crystal clock
    input  wire logic                     rst_n,     // sync reset, low
    input  wire rtcct_pkg::rtcct_alarm_type setting, // stored compare time
    input  wire logic [7:0]               nowMinute, // live minute count
    input  wire logic [7:0]               nowHour,   // live hour count
    output logic                          match      // registered equality
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            match <= 1'b0;
        end else begin
            match <= (setting.minute[6:0] == nowMinute[6:0]) &&
                     (setting.hour[5:0] == nowHour[5:0]);
        end
    end
endmodule

// ### logic/rtcct_calendar.sv
// calendar counter, time trimming and alarm time registers of the clock
//
// How it works
// - long months count days 01 to 31 in bcd
// - april, june, september, november count days 01 to 30
// - february ends at 29 in leap years, else at 28
// - day wrap to 01 steps the month
// - month counts 01 to 12; wrap carries into the year
// - year counts 00 to 99; multiples of four are leap years
// - day field six bits at 4h, bits 7:6 read zero
// - month field five bits at 5h, bits 7:5 read zero
// - year is full eight bits at 6h, all read and write
// - trim bit 7 selects 32.768 kHz (0) or 32.000 kHz (1)
// - untrimmed second is 32768 or 32000 oscillator cycles
// - trim only applies to the second after 00, 20 or 40
// - sign clear lengthens by (magnitude minus one) times two
// - sign set shortens by (inverted magnitude plus one) times two
// - magnitude bits 5:1 all zero means no correction
// - trim changes only the count, never the clock output
// - oscillator halt clears trim; calendar and alarms undefined
// - alarm a minute at 8h, hour at 9h, upper bits zero
// - alarm b minute at bh, hour at ch, same layout
// - alarm hour bit 5 is pm or hour-tens twenty
// - day steps when the hour rolls to midnight
// - weekday steps on each day carry, codes 0 to 6
`timescale 1ns/1ns
`include "rtcct_regs.svh"
module rtcct_calendar (
    input  wire logic                   clk,                    // crystal clock
    input  wire logic                   rst_n,                  // sync reset, low
    input  wire logic                   oscillator_halted_flag, // halt sensed
    input  wire rtcct_pkg::rtcct_wr_type regWrite,              // host write
    input  wire logic [3:0]             regAddr,                // host read address
    output logic      [7:0]             regRdata,               // read data
    input  wire logic [7:0]             secondsNow,             // live seconds bcd
    input  wire logic [7:0]             minutesNow,             // live minutes bcd
    input  wire logic [7:0]             hoursNow,               // live hours bcd
    input  wire logic                   hourMode24,             // 24-hour display
    output logic                        secondTick,             // advance seconds
    output logic                        dayCarry,               // midnight pulse
    output logic      [2:0]             weekday_code,           // weekday count
    output logic                        alarmAMatch,            // alarm a equal
    output logic                        alarmBMatch,            // alarm b equal
    output logic                        clockOut                // untrimmed clock
);
    //////////////////////////////////////////////////////////////////////////
    logic [7:0] dayReg;
    logic [7:0] monthReg;
    logic [7:0] yearReg;
    logic [7:0] trimReg;
    logic [7:0] trimActiveReg;
    rtcct_pkg::rtcct_alarm_type alarmAReg;
    rtcct_pkg::rtcct_alarm_type alarmBReg;
    logic [16:0] cycleReg;
    logic [16:0] periodNext;
    logic [7:0]  hourPrevReg;
    logic [7:0]  lastDay;
    logic [7:0]  dayStepped;
    logic [7:0]  monthStepped;
    logic [7:0]  yearStepped;
    logic        dayWrap;
    logic        monthWrap;
    logic        leapYear;
    logic        midnight;
    logic        trimSecond;
    logic        writeHit;
    rtcct_pkg::rtcct_month_kind_type monthKind;

    assign writeHit = regWrite.write;
    assign clockOut = clk;

    //////////////////////////////////////////////////////////////////////////
    // month length and leap year
    assign leapYear = (yearReg[0] == 1'b0) && (yearReg[1] == yearReg[4]);

    always_comb begin
        case (monthReg[4:0])
            5'h04, 5'h06, 5'h09, 5'h11: monthKind = rtcct_pkg::RTCCT_MONTH_SHORT;
            5'h02:                      monthKind = rtcct_pkg::RTCCT_MONTH_FEB;
            default:                    monthKind = rtcct_pkg::RTCCT_MONTH_LONG;
        endcase
    end

    always_comb begin
        case (monthKind)
            rtcct_pkg::RTCCT_MONTH_SHORT: lastDay = 8'h30;
            rtcct_pkg::RTCCT_MONTH_FEB:   lastDay = leapYear ? 8'h29 : 8'h28;
            default:                      lastDay = 8'h31;
        endcase
    end

    rtcct_bcd_digit #(.WIDTH(8)) dayStep (
        .value   (dayReg),
        .first   (8'h01),
        .last    (lastDay),
        .stepped (dayStepped),
        .wrapped (dayWrap)
    );

    rtcct_bcd_digit #(.WIDTH(8)) monthStep (
        .value   (monthReg),
        .first   (8'h01),
        .last    (8'h12),
        .stepped (monthStepped),
        .wrapped (monthWrap)
    );

    rtcct_bcd_digit #(.WIDTH(8)) yearStep (
        .value   (yearReg),
        .first   (8'h00),
        .last    (8'h99),
        .stepped (yearStepped),
        .wrapped ()
    );

    //////////////////////////////////////////////////////////////////////////
    // midnight detection from the hour counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hourPrevReg <= 8'h00;
        end else begin
            hourPrevReg <= hoursNow;
        end
    end

    always_comb begin
        if (hourMode24) begin
            midnight = (hourPrevReg[5:0] == 6'h23) && (hoursNow[5:0] == 6'h00);
        end else begin
            midnight = (hourPrevReg[5:0] == 6'h31) && (hoursNow[5:0] == 6'h12);
        end
    end
    assign dayCarry = midnight;

    //////////////////////////////////////////////////////////////////////////
    // calendar counters; host writes win over carries
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dayReg <= `RTCCT_DAY_RESET;
        end else if (writeHit && regWrite.addr == `RTCCT_ADDR_DAY) begin
            dayReg <= regWrite.data & `RTCCT_DAY_MASK;
        end else if (midnight) begin
            dayReg <= dayStepped;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            monthReg <= `RTCCT_MONTH_RESET;
        end else if (writeHit && regWrite.addr == `RTCCT_ADDR_MONTH) begin
            monthReg <= regWrite.data & `RTCCT_MONTH_MASK;
        end else if (midnight && dayWrap) begin
            monthReg <= monthStepped;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            yearReg <= `RTCCT_YEAR_RESET;
        end else if (writeHit && regWrite.addr == `RTCCT_ADDR_YEAR) begin
            yearReg <= regWrite.data;
        end else if (midnight && dayWrap && monthWrap) begin
            yearReg <= yearStepped;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            weekday_code <= 3'h0;
        end else if (midnight) begin
            weekday_code <= (weekday_code >= 3'h6) ? 3'h0 : weekday_code + 3'h1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // alarm time registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alarmAReg <= {`RTCCT_ALARM_RESET, `RTCCT_ALARM_RESET};
            alarmBReg <= {`RTCCT_ALARM_RESET, `RTCCT_ALARM_RESET};
        end else if (writeHit) begin
            case (regWrite.addr)
                `RTCCT_ADDR_AMIN:  alarmAReg.minute <= regWrite.data & `RTCCT_MIN_MASK;
                `RTCCT_ADDR_AHOUR: alarmAReg.hour <= regWrite.data & `RTCCT_HOUR_MASK;
                `RTCCT_ADDR_BMIN:  alarmBReg.minute <= regWrite.data & `RTCCT_MIN_MASK;
                `RTCCT_ADDR_BHOUR: alarmBReg.hour <= regWrite.data & `RTCCT_HOUR_MASK;
                default: begin
                end
            endcase
        end
    end

    rtcct_alarm_cmp alarmA (
        .clk       (clk),
        .rst_n     (rst_n),
        .setting   (alarmAReg),
        .nowMinute (minutesNow),
        .nowHour   (hoursNow),
        .match     (alarmAMatch)
    );

    rtcct_alarm_cmp alarmB (
        .clk       (clk),
        .rst_n     (rst_n),
        .setting   (alarmBReg),
        .nowMinute (minutesNow),
        .nowHour   (hoursNow),
        .match     (alarmBMatch)
    );

    //////////////////////////////////////////////////////////////////////////
    // trim register; halt flag forces zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trimReg <= `RTCCT_TRIM_RESET;
        end else if (oscillator_halted_flag) begin
            trimReg <= `RTCCT_TRIM_RESET;
        end else if (writeHit && regWrite.addr == `RTCCT_ADDR_TRIM) begin
            trimReg <= regWrite.data;
        end
    end

    assign trimSecond = (secondsNow == 8'h00) || (secondsNow == 8'h20) ||
                        (secondsNow == 8'h40);

    // period length for the second about to start
    always_comb begin
        periodNext = trimReg[`RTCCT_TRIM_XSEL_BIT] ? `RTCCT_CYC_32000 : `RTCCT_CYC_32768;
        if (trimSecond && trimReg[5:1] != 5'h00) begin
            if (!trimReg[`RTCCT_TRIM_SIGN_BIT]) begin
                periodNext = periodNext + {10'h000, trimReg[5:0] - 6'h01, 1'b0};
            end else begin
                periodNext = periodNext - {10'h000, ~trimReg[5:0] + 6'h01, 1'b0};
            end
        end
    end

    // the second counter: reload at each tick from trimReg, which is latched into trimActiveReg
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trimActiveReg <= `RTCCT_TRIM_RESET;
            cycleReg      <= 17'h00001;
        end else if (cycleReg <= 17'h00001) begin
            trimActiveReg <= trimReg;
            cycleReg      <= periodNext;
        end else begin
            cycleReg <= cycleReg - 17'h00001;
        end
    end
    assign secondTick = (cycleReg == 17'h00001);

    //////////////////////////////////////////////////////////////////////////
    // register read port
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else begin
            case (regAddr)
                `RTCCT_ADDR_DAY:   regRdata <= dayReg & `RTCCT_DAY_MASK;
                `RTCCT_ADDR_MONTH: regRdata <= monthReg & `RTCCT_MONTH_MASK;
                `RTCCT_ADDR_YEAR:  regRdata <= yearReg;
                `RTCCT_ADDR_TRIM:  regRdata <= trimReg;
                `RTCCT_ADDR_AMIN:  regRdata <= alarmAReg.minute;
                `RTCCT_ADDR_AHOUR: regRdata <= alarmAReg.hour;
                `RTCCT_ADDR_BMIN:  regRdata <= alarmBReg.minute;
                `RTCCT_ADDR_BHOUR: regRdata <= alarmBReg.hour;
                default:           regRdata <= 8'h00;
            endcase
        end
    end
endmodule

// ### tb/rtcct_calendar_asserts.sv
// checker for the calendar, trim and alarm block
`timescale 1ns/1ns
`include "rtcct_regs.svh"
module rtcct_calendar_asserts (
    input wire logic       clk,          // crystal clock
    input wire logic       rst_n,        // sync reset, low
    input wire logic [3:0] regAddr,      // read address
    input wire logic [7:0] regRdata,     // read data
    input wire logic [7:0] hoursNow,     // live hours
    input wire logic       hourMode24,   // 24-hour mode
    input wire logic       secondTick,   // seconds advance
    input wire logic       dayCarry,     // midnight pulse
    input wire logic [2:0] weekday_code, // weekday count
    input wire logic       alarmAMatch,  // alarm a equal
    input wire logic       alarmBMatch   // alarm b equal
);
    logic [16:0] sinceTick_reg;
    logic        tickSeen_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // cycles since the last tick
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sinceTick_reg <= 17'h00000;
        end else if (secondTick) begin
            sinceTick_reg <= 17'h00001;
        end else begin
            sinceTick_reg <= sinceTick_reg + 17'h00001;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tickSeen_reg <= 1'b0;
        end else if (secondTick) begin
            tickSeen_reg <= 1'b1;
        end
    end
    ////////////////////////////////////////
    a_tick_pulse: assert property (secondTick |=> !secondTick)
        else $error("tick longer than one cycle");
    a_tick_period: assert property (secondTick && tickSeen_reg |->
        sinceTick_reg inside {[17'h07c80:17'h0807c]}) else $error("second length out of range");
    a_carry_24h: assert property (hourMode24 && $past(hoursNow) == 8'h23
        && hoursNow == 8'h00 |-> ##[0:1] dayCarry) else $error("no carry at 24h midnight");
    a_carry_12h: assert property (!hourMode24 && $past(hoursNow) == 8'h31
        && hoursNow == 8'h12 |-> ##[0:1] dayCarry) else $error("no carry at 12h midnight");
    a_carry_pulse: assert property (dayCarry |=> !dayCarry)
        else $error("day carry longer than one cycle");
    a_carry_cause: assert property (dayCarry |-> hoursNow inside {8'h00, 8'h12})
        else $error("day carry away from midnight");
    a_week_step: assert property ($changed(weekday_code) |-> weekday_code ==
        (($past(weekday_code) == 3'h6) ? 3'h0 : $past(weekday_code) + 3'h1))
        else $error("weekday stepped wrongly");
    a_week_cause: assert property ($changed(weekday_code) |-> dayCarry || $past(dayCarry))
        else $error("weekday moved without carry");
    a_day_mask: assert property (regAddr == `RTCCT_ADDR_DAY |=> regRdata[7:6] == 2'b00)
        else $error("day upper bits not zero");
    a_month_mask: assert property (regAddr == `RTCCT_ADDR_MONTH |=> regRdata[7:5] == 3'h0)
        else $error("month upper bits not zero");
    c_carry: cover property (dayCarry);
    c_tick: cover property (secondTick && tickSeen_reg);
    c_alarms: cover property (alarmAMatch && !alarmBMatch);
endmodule
bind rtcct_calendar rtcct_calendar_asserts i_chk (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regRdata(regRdata), .hoursNow(hoursNow), .hourMode24(hourMode24),
    .secondTick(secondTick), .dayCarry(dayCarry), .weekday_code(weekday_code),
    .alarmAMatch(alarmAMatch), .alarmBMatch(alarmBMatch));

// ### tb/rtcct_time_model.sv
// model of the host time counters feeding the calendar
`timescale 1ns/1ns
module rtcct_time_model (
    input  wire logic       clk,        // crystal clock
    input  wire logic       rst_n,      // sync reset, low
    input  wire logic       secondTick, // advance seconds
    input  wire logic       load,       // preset strobe
    input  wire logic [7:0] setSec,     // preset seconds
    input  wire logic [7:0] setMin,     // preset minutes
    input  wire logic [7:0] setHour,    // preset hours
    output logic      [7:0] secondsNow, // live seconds
    output logic      [7:0] minutesNow, // live minutes
    output logic      [7:0] hoursNow    // live hours
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            secondsNow <= 8'h00;
            minutesNow <= 8'h00;
            hoursNow <= 8'h00;
        end else if (load) begin
            secondsNow <= setSec;
            minutesNow <= setMin;
            hoursNow <= setHour;
        end else if (secondTick) begin
            if (secondsNow == 8'h59) begin
                secondsNow <= 8'h00;
            end else if (secondsNow[3:0] == 4'h9) begin
                secondsNow <= {secondsNow[7:4] + 4'h1, 4'h0};
            end else begin
                secondsNow <= secondsNow + 8'h01;
            end
        end
    end
endmodule

// ### tb/rtcct_calendar_bench.sv
// self-checking bench for the calendar, trim and alarm block
`timescale 1ns/1ns
`include "rtcct_regs.svh"
module rtcct_calendar_bench;
    logic                    clk = 1'b0, rst_n = 1'b0, halt = 1'b0, hourMode24 = 1'b1;
    rtcct_pkg::rtcct_wr_type regWrite = '0;
    logic [3:0]              regAddr = 4'h0;
    logic                    load = 1'b0;
    logic [7:0]              setSec = 8'h00, setMin = 8'h00, setHour = 8'h00;
    logic [7:0]              regRdata, secondsNow, minutesNow, hoursNow;
    logic [2:0]              weekday_code;
    logic                    secondTick, dayCarry, alarmAMatch, alarmBMatch, clockOut;
    int                      num_errors = 0, n_compared = 0, cycles = 0;
    int                      tickLast = 0, tickPrev = 0, ticks = 0;
    always #2 clk = ~clk;
    rtcct_calendar i_dut (.clk(clk), .rst_n(rst_n), .oscillator_halted_flag(halt),
        .regWrite(regWrite), .regAddr(regAddr), .regRdata(regRdata),
        .secondsNow(secondsNow), .minutesNow(minutesNow), .hoursNow(hoursNow),
        .hourMode24(hourMode24), .secondTick(secondTick), .dayCarry(dayCarry),
        .weekday_code(weekday_code), .alarmAMatch(alarmAMatch),
        .alarmBMatch(alarmBMatch), .clockOut(clockOut));
    rtcct_time_model i_host (.clk(clk), .rst_n(rst_n), .secondTick(secondTick),
        .load(load), .setSec(setSec), .setMin(setMin), .setHour(setHour),
        .secondsNow(secondsNow), .minutesNow(minutesNow), .hoursNow(hoursNow));
    ////////////////////////////////////////
    task finish_test;
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        cycles++;
        if (secondTick === 1'b1) begin
            tickPrev = tickLast;
            tickLast = cycles;
            ticks++;
        end
        if (cycles > 100000) begin
            num_errors++;
            finish_test();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrite = '{1'b1, a, d};
        @(negedge clk);
        regWrite.write = 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(negedge clk);
        regAddr = a;
        @(negedge clk);
        chk($sformatf("register %h", a), {24'h0, e}, {24'h0, regRdata});
    endtask
    task set_time(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
        @(negedge clk);
        load = 1'b1;
        setSec = s;
        setMin = m;
        setHour = h;
        @(negedge clk);
        load = 1'b0;
    endtask
    task wait_tick;
        int n;
        n = ticks;
        repeat (40000) if (ticks == n) @(negedge clk);
    endtask
    ////////////////////////////////////////
    task t_regs;
        logic [3:0] a [8];
        logic [7:0] rv [8];
        logic [7:0] mk [8];
        a = '{`RTCCT_ADDR_DAY, `RTCCT_ADDR_MONTH, `RTCCT_ADDR_YEAR, `RTCCT_ADDR_TRIM,
              `RTCCT_ADDR_AMIN, `RTCCT_ADDR_AHOUR, `RTCCT_ADDR_BMIN, `RTCCT_ADDR_BHOUR};
        rv = '{`RTCCT_DAY_RESET, `RTCCT_MONTH_RESET, `RTCCT_YEAR_RESET, 8'h00,
               `RTCCT_ALARM_RESET, `RTCCT_ALARM_RESET, `RTCCT_ALARM_RESET, `RTCCT_ALARM_RESET};
        mk = '{8'h3f, 8'h1f, 8'hff, 8'hff, 8'h7f, 8'h3f, 8'h7f, 8'h3f};
        for (int i = 0; i < 8; i++) rd(a[i], rv[i]);
        for (int i = 0; i < 8; i++) wr(a[i], 8'hff);
        wr(4'ha, 8'h5a);
        for (int i = 0; i < 8; i++) rd(a[i], mk[i]);
        halt = 1'b1;
        wr(`RTCCT_ADDR_TRIM, 8'h55);
        halt = 1'b0;
        rd(`RTCCT_ADDR_TRIM, 8'h00);
        for (int i = 0; i < 8; i++) wr(a[i], rv[i]);
        $display("register test done");
    endtask
    task t_cal;
        logic [7:0] c [8][6];
        c = '{'{8'h31, 8'h01, 8'h23, 8'h01, 8'h02, 8'h23}, '{8'h30, 8'h04, 8'h23, 8'h01, 8'h05, 8'h23},
              '{8'h28, 8'h02, 8'h23, 8'h01, 8'h03, 8'h23}, '{8'h28, 8'h02, 8'h24, 8'h29, 8'h02, 8'h24},
              '{8'h29, 8'h02, 8'h00, 8'h01, 8'h03, 8'h00}, '{8'h31, 8'h12, 8'h99, 8'h01, 8'h01, 8'h00},
              '{8'h30, 8'h01, 8'h23, 8'h31, 8'h01, 8'h23}, '{8'h29, 8'h02, 8'h96, 8'h01, 8'h03, 8'h96}};
        for (int i = 0; i < 8; i++) begin
            hourMode24 = (i != 7);
            wr(`RTCCT_ADDR_DAY, c[i][0]);
            wr(`RTCCT_ADDR_MONTH, c[i][1]);
            wr(`RTCCT_ADDR_YEAR, c[i][2]);
            set_time(8'h00, 8'h59, (i != 7) ? 8'h23 : 8'h31);
            set_time(8'h00, 8'h00, (i != 7) ? 8'h00 : 8'h12);
            repeat (3) @(negedge clk);
            rd(`RTCCT_ADDR_DAY, c[i][3]);
            rd(`RTCCT_ADDR_MONTH, c[i][4]);
            rd(`RTCCT_ADDR_YEAR, c[i][5]);
            chk("weekday", (i + 1) % 7, {29'h0, weekday_code});
        end
        $display("calendar test done");
    endtask
    task t_alarm;
        wr(`RTCCT_ADDR_AMIN, 8'h30);
        wr(`RTCCT_ADDR_AHOUR, 8'h21);
        wr(`RTCCT_ADDR_BMIN, 8'h59);
        wr(`RTCCT_ADDR_BHOUR, 8'h12);
        set_time(8'h00, 8'h30, 8'h21);
        repeat (3) @(negedge clk);
        chk("alarm a", 1, {31'h0, alarmAMatch});
        chk("alarm b", 0, {31'h0, alarmBMatch});
        set_time(8'h00, 8'h59, 8'h12);
        repeat (3) @(negedge clk);
        chk("alarm a", 0, {31'h0, alarmAMatch});
        chk("alarm b", 1, {31'h0, alarmBMatch});
        $display("alarm test done");
    endtask
    task t_trim;
        wr(`RTCCT_ADDR_TRIM, 8'hfe);
        set_time(8'h00, 8'h00, 8'h00);
        wait_tick();
        chk("plain second", 32'h00008000, tickLast - tickPrev);
        wr(`RTCCT_ADDR_TRIM, 8'h87);
        set_time(8'h20, 8'h00, 8'h00);
        wait_tick();
        chk("short second", 32'h00007d00 - 32'h4, tickLast - tickPrev);
        wait_tick();
        chk("long second", 32'h00007d00 + 32'hc, tickLast - tickPrev);
        chk("clock output", {31'h0, clk}, {31'h0, clockOut});
        $display("trim test done");
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        t_cal();
        t_alarm();
        t_trim();
        finish_test();
    end
endmodule
